// File: design/swd_edge.sv
`timescale 1ns/1ps
// Registers the kick input and flags each rising edge seen while clr_i is low
module swd_edge (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic kick_i,
  output logic rise_o
);
  logic prev_r;
  logic prev_nxt;
  logic rise_r;
  logic rise_nxt;

  always_comb begin
    prev_nxt = clr_i ? kick_i : kick_i;
    rise_nxt = ~clr_i & kick_i & ~prev_r;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign rise_o = rise_r;
endmodule // swd_edge

// File: design/swd_pkg.sv
package swd_pkg;
  // Timebase
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int CYC_PER_MS = 1_000_000 / CLK_NS;
  // Start delay, 140 ms
  localparam int START_MS = 140;
  localparam int START_CYC = START_MS * CYC_PER_MS;
  // Fault pulse width, 2 ms
  localparam int FAULT_MS = 2;
  localparam int FAULT_CYC = FAULT_MS * CYC_PER_MS;
  // Resistor scale, 3.240 kohm per ms, held in ohm
  localparam int RES_OHM_PER_MS = 3240;
  // Default resistor 324 kohm (100 ms)
  localparam int RES_DEFAULT_OHM = 324_000;
  localparam int RES_W = 20;
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

  typedef enum logic [1:0] {
    SWD_IDLE,
    SWD_START,
    SWD_RUN,
    SWD_PULSE
  } swd_state_t;
endpackage

// File: design/swd_supervisor_watchdog.sv
`timescale 1ns/1ps
module swd_supervisor_watchdog #(
  parameter int START_CYC = swd_pkg::START_CYC,
  parameter int FAULT_CYC = swd_pkg::FAULT_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic kick_clock_in_i,
  input wire logic supervisor_enable_n_i,
  input wire logic [3:0] rail_good_i,
  input wire logic [swd_pkg::RES_W-1:0] timeout_program_pin_i,
  output logic system_reset_out_n_o,
  output logic system_reset_out_n_oe_o,
  output logic supervisor_fault_o,
  output logic armed_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Qualifying conditions
  logic all_good;
  logic clear;
  logic rise;
  logic [swd_pkg::CNT_W-1:0] timeout_cyc;

  assign all_good = &rail_good_i;
  assign clear = supervisor_enable_n_i | ~all_good;

  function automatic logic [swd_pkg::CNT_W-1:0] res_to_cyc(input logic [swd_pkg::RES_W-1:0] res);
    logic [63:0] prod;
    prod = 64'(res) * 64'(swd_pkg::CYC_PER_MS) / 64'(swd_pkg::RES_OHM_PER_MS);
    return (prod == 64'h0) ? swd_pkg::CNT_ONE : prod[swd_pkg::CNT_W-1:0];
  endfunction

  assign timeout_cyc = res_to_cyc(timeout_program_pin_i);

  swd_edge u_edge (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .clr_i(clear),
    .kick_i(kick_clock_in_i),
    .rise_o(rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Span decoding
  // True on the last cycle of a span counted from zero
  function automatic logic span_end(input logic [swd_pkg::CNT_W-1:0] cnt, input logic [swd_pkg::CNT_W-1:0] span);
    return cnt >= span - swd_pkg::CNT_ONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  swd_pkg::swd_state_t state_r;
  swd_pkg::swd_state_t state_nxt;
  logic [swd_pkg::CNT_W-1:0] cnt_r;
  logic [swd_pkg::CNT_W-1:0] cnt_nxt;
  logic [swd_pkg::CNT_W-1:0] stuck_r;
  logic [swd_pkg::CNT_W-1:0] stuck_nxt;
  logic [swd_pkg::CNT_W-1:0] start_span;
  logic [swd_pkg::CNT_W-1:0] fault_span;
  logic [swd_pkg::CNT_W-1:0] stuck_span;
  logic start_done;
  logic period_late;
  logic pulse_done;
  logic stuck;
  logic armed_r;
  logic armed_nxt;
  logic fault_r;
  logic fault_nxt;
  logic oe_r;
  logic oe_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Span ends
  assign start_span = swd_pkg::CNT_W'(START_CYC);
  assign fault_span = swd_pkg::CNT_W'(FAULT_CYC);
  assign start_done = span_end(cnt_r, start_span);
  assign period_late = span_end(cnt_r, timeout_cyc);
  assign pulse_done = span_end(cnt_r, fault_span);
  // Start delay plus timeout with no edge
  assign stuck_span = start_span + timeout_cyc;
  assign stuck = stuck_r >= stuck_span;

  ////////////////////////////////////////////////////////////////////////////
  // State machine
  always_comb begin
    state_nxt = state_r;
    if (clear) begin
      state_nxt = swd_pkg::SWD_IDLE;
    end else begin
      case (state_r)
        swd_pkg::SWD_IDLE: begin
          state_nxt = swd_pkg::SWD_START;
        end
        swd_pkg::SWD_START: begin
          if (start_done) begin
            state_nxt = swd_pkg::SWD_RUN;
          end
        end
        swd_pkg::SWD_RUN: begin
          if (!rise && (period_late || stuck)) begin
            state_nxt = swd_pkg::SWD_PULSE;
          end
        end
        swd_pkg::SWD_PULSE: begin
          if (pulse_done) begin
            state_nxt = swd_pkg::SWD_IDLE;
          end
        end
        default: begin
          state_nxt = swd_pkg::SWD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= swd_pkg::SWD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Span counter
  always_comb begin
    cnt_nxt = cnt_r + swd_pkg::CNT_ONE;
    if (clear || state_nxt != state_r) begin
      // Every state entry starts a fresh span
      cnt_nxt = swd_pkg::CNT_ZERO;
    end else if (state_r == swd_pkg::SWD_RUN && rise) begin
      cnt_nxt = swd_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= swd_pkg::CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stuck kick backstop
  always_comb begin
    stuck_nxt = stuck_r + swd_pkg::CNT_ONE;
    // Counts from regulator startup until an edge
    if (clear || rise || state_r == swd_pkg::SWD_IDLE || state_r == swd_pkg::SWD_PULSE) begin
      stuck_nxt = swd_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stuck_r <= swd_pkg::CNT_ZERO;
    end else begin
      stuck_r <= stuck_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flags
  always_comb begin
    // Armed only while periods are timed
    armed_nxt = (state_nxt == swd_pkg::SWD_RUN);
    // Fault pulse follows the pulse state
    fault_nxt = (state_nxt == swd_pkg::SWD_PULSE);
    oe_nxt = fault_nxt;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed_r <= 1'b0;
      fault_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
      fault_r <= fault_nxt;
      oe_r <= oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain data is always low; only the enable moves
  assign system_reset_out_n_o = 1'b0;
  assign system_reset_out_n_oe_o = oe_r;
  assign supervisor_fault_o = fault_r;
  assign armed_o = armed_r;
endmodule // swd_supervisor_watchdog

// File: tb/swd_asserts.sv
`timescale 1ns/1ps
module swd_asserts #(
  parameter int START_CYC = 1,
  parameter int FAULT_CYC = 1
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic kick_clock_in_i,
  input wire logic supervisor_enable_n_i,
  input wire logic [3:0] rail_good_i,
  input wire logic [swd_pkg::RES_W-1:0] timeout_program_pin_i,
  input wire logic system_reset_out_n_o,
  input wire logic system_reset_out_n_oe_o,
  input wire logic supervisor_fault_o,
  input wire logic armed_o
);
  logic k_r;
  int kc_r, fc_r, qc_r, to;
  wire logic ok = !supervisor_enable_n_i && &rail_good_i;
  assign to = int'(timeout_program_pin_i) * 10000 / 3240;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {k_r, kc_r, fc_r, qc_r} <= '0;
    end else begin
      k_r <= kick_clock_in_i;
      kc_r <= (kick_clock_in_i && !k_r) || !armed_o ? 0 : kc_r + 1;
      fc_r <= supervisor_fault_o ? fc_r + 1 : 0;
      qc_r <= ok && !supervisor_fault_o ? qc_r + 1 : 0;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_pin_low: assert property (!system_reset_out_n_o) else $error("reset data high");
  a_pin_pulse: assert property (system_reset_out_n_oe_o == supervisor_fault_o) else $error("oe not fault");
  a_off_clears: assert property (!ok |=> !armed_o && !supervisor_fault_o) else $error("not cleared");
  a_arm_delay: assert property ($rose(armed_o) |-> qc_r inside {[START_CYC:START_CYC + 4]}) else $error("arm");
  a_fault_armed: assert property ($rose(supervisor_fault_o) |-> $past(armed_o)) else $error("unarmed");
  a_fault_late: assert property ($rose(supervisor_fault_o) |-> kc_r + 4 >= to) else $error("early");
  a_kick_limit: assert property (armed_o |-> kc_r <= to + 4) else $error("fault missed");
  a_pulse_width: assert property ($fell(supervisor_fault_o) && ok |-> fc_r == FAULT_CYC) else $error("width");
endmodule // swd_asserts
bind swd_supervisor_watchdog swd_asserts #(.START_CYC(START_CYC), .FAULT_CYC(FAULT_CYC)) u_chk (.mclk_i, .nrst_i,
  .kick_clock_in_i, .supervisor_enable_n_i, .rail_good_i, .timeout_program_pin_i, .system_reset_out_n_o,
  .system_reset_out_n_oe_o, .supervisor_fault_o, .armed_o);

// File: tb/swd_host.sv
`timescale 1ns/1ps
module swd_host (
  input wire logic mclk_i,
  input wire logic run_i,
  input wire logic [15:0] period_i,
  output logic kick_o
);
  int n_r = 0;
  initial kick_o = 1'b0;
  always @(posedge mclk_i) begin
    if (run_i) begin
      n_r <= n_r + 1 >= int'(period_i) ? 0 : n_r + 1;
      kick_o <= n_r < int'(period_i) / 2;
    end
  end
endmodule // swd_host

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int SC = 50;
  localparam int FC = 8;
  logic mclk_i = 1'b0, nrst_i = 1'b0, en_n = 1'b1, run = 1'b0, kick, oe, dat, fault, armed;
  logic [3:0] rails = 4'h0;
  logic [19:0] pin = 20'h00144;
  logic [15:0] per = 16'h0064;
  int mismatches = 0, checks = 0, cyc = 0, to, t;
  swd_supervisor_watchdog #(.START_CYC(SC), .FAULT_CYC(FC)) DUT (.mclk_i, .nrst_i, .kick_clock_in_i(kick),
    .supervisor_enable_n_i(en_n), .rail_good_i(rails), .timeout_program_pin_i(pin), .system_reset_out_n_o(dat),
    .system_reset_out_n_oe_o(oe), .supervisor_fault_o(fault), .armed_o(armed));
  swd_host u_host (.mclk_i, .run_i(run), .period_i(per), .kick_o(kick));
  initial forever #50 mclk_i = ~mclk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wait_fault(output int n);
    n = 0;
    while (fault !== 1'b1 && n < 5000) begin
      step(1);
      n++;
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32));
    step(4);
    nrst_i = 1'b1;
    chk({oe, fault, armed}, 3'h0);
    rails = 4'hF;
    step(2 * SC);
    chk(armed, 1'b0);
    en_n = 1'b0;
    step(SC - 1);
    chk(armed, 1'b0);
    step(6);
    chk(armed, 1'b1);
    $display("test arm done");
    pin = 20'(200 + $urandom % 200);
    to = int'(pin) * 10000 / 3240;
    per = 16'(to / 2 + $urandom % (to / 4));
    run = 1'b1;
    repeat (6) begin
      step(int'(per));
      chk(fault, 1'b0);
    end
    run = 1'b0;
    wait_fault(t);
    chk(t >= to - int'(per) && t <= to + 4, 1);
    chk({oe, dat}, 2'h2);
    t = 0;
    while (fault === 1'b1 && t < 100) begin
      step(1);
      t++;
    end
    chk(t, FC);
    wait_fault(t);
    chk(t >= SC + to && t <= SC + to + 6, 1);
    $display("test timeout done");
    step(FC + SC + 10);
    chk(armed, 1'b1);
    en_n = 1'b1;
    step(2);
    chk({armed, fault}, 2'h0);
    en_n = 1'b0;
    step(SC + 10);
    rails = ~(4'h1 << $urandom % 4);
    step(2);
    chk(armed, 1'b0);
    $display("test clear done");
    summarize();
  end
endmodule // tb_top
